/* File: hdl/edge_sync.sv */
// Two-stage synchroniser with falling-edge detector for the event pin
`timescale 1ns/1ps
module edge_sync
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// Asynchronous pin and results
	input  wire logic pinIn,
	output logic      pinLevel,
	output logic      fallPulse
);
	logic stage1;
	logic stage2;
	logic stage3;

	// Only stage2 reads stage1; edge logic looks at stage2 and stage3
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			stage1 <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign pinLevel  = stage2;
	assign fallPulse = stage3 & ~stage2;
endmodule

/* File: hdl/prescaler.sv */
// Free-running instruction clock divider giving one-cycle count ticks
`timescale 1ns/1ps
`include "timer_zero_defines.svh"
module prescaler
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// Rate code and tick
	input  wire logic [2:0] rateSel,
	output logic            tick
);
	logic [`PRESCALE_W-1:0] divCount;
	logic [`PRESCALE_W-1:0] next_divCount;
	logic [`PRESCALE_W-1:0] divMask;

	// Code 000 divides by 256 down to 111 by 2
	assign divMask       = `BYTE_FULL >> rateSel;
	assign next_divCount = divCount + 8'h01;
	assign tick          = (divCount & divMask) == divMask;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			divCount <= `BYTE_ZERO;
		else
			divCount <= next_divCount;
	end
endmodule

/* File: hdl/timer_zero.sv */
// 8-bit timer with event counting, overflow toggle output and PWM, APB slave
`timescale 1ns/1ps
`include "timer_zero_defines.svh"
module timer_zero
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Event pin, its GPIO services
	input  wire logic        event_input_pin,
	input  wire logic        powerSaving,
	output logic             pinWake,
	output logic             pinIrq,
	// Shared output pin
	output logic             shared_output_pin,
	output logic             sharedPinOe_b,
	// Overflow interrupt
	output logic             overflowIrq
);
	import timer_zero_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [`MODE_WIDTH-1:0] timer_mode_control;
	timer_zero_pkg::byte_t  count_value;
	timer_zero_pkg::byte_t  reloadBuffer;
	timer_zero_pkg::byte_t  reload_value;
	logic                   overflow_flag;
	logic                   pin_interrupt_flag;
	logic                   toggleState;
	logic                   pwmState;
	logic                   gpioOut;
	logic                   gpioOe;
	logic                   enableSeen;
	logic                   pinLevel;
	logic                   pinFall;
	logic                   preTick;

	// Mode field views
	logic       pwm_output_enable;
	logic       toggle_output_enable;
	logic       auto_reload_enable;
	logic       event_source_select;
	logic [2:0] prescale_select;
	logic       timer_enable;
	logic       overflow_irq_enable;
	assign pwm_output_enable    = timer_mode_control[`MODE_PWM_BIT];
	assign toggle_output_enable = timer_mode_control[`MODE_TOG_BIT];
	assign auto_reload_enable   = timer_mode_control[`MODE_ALD_BIT];
	assign event_source_select  = timer_mode_control[`MODE_SRC_BIT];
	assign prescale_select      = timer_mode_control[`MODE_RATE_MSB:`MODE_RATE_LSB];
	assign timer_enable         = timer_mode_control[`MODE_ENB_BIT];
	assign overflow_irq_enable  = timer_mode_control[`MODE_IEN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Count mask for a resolution; the event source always runs all 8 bits
	function automatic timer_zero_pkg::byte_t boundaryMask(input resolution_t res);
		case (res)
			RES_64:  boundaryMask = `MASK_64;
			RES_32:  boundaryMask = `MASK_32;
			RES_16:  boundaryMask = `MASK_16;
			default: boundaryMask = `BYTE_FULL;
		endcase
	endfunction

	// Byte address match
	function automatic logic hit(input logic [11:0] a, input logic [11:0] want);
		hit = (a == want);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and prescaler
	edge_sync eventSync
	(
		.clock     (clock),
		.rst_b     (rst_b),
		.pinIn     (event_input_pin),
		.pinLevel  (pinLevel),
		.fallPulse (pinFall)
	);

	prescaler rateDivider
	(
		.clock   (clock),
		.rst_b   (rst_b),
		.rateSel (prescale_select),
		.tick    (preTick)
	);

	////////////////////////////////////////////////////////////////////////
	// Count path decode
	resolution_t           resolution;
	timer_zero_pkg::byte_t countMask;
	timer_zero_pkg::byte_t countNext;
	logic                  countTick;
	logic                  overflow;
	logic                  pwmMode;
	logic                  enableRise;
	logic                  busWrite;
	logic                  busRead;
	logic                  wrMode;
	logic                  wrCount;
	logic                  wrReload;
	logic                  wrStatus;
	logic                  wrGpio;
	logic                  mapped;
	pin_owner_t            pinOwner;

	// PWM only with source internal; bits pick resolution only when PWM on
	assign pwmMode    = pwm_output_enable & ~event_source_select;
	assign resolution = pwmMode ? resolution_t'({auto_reload_enable, toggle_output_enable})
	                            : RES_256;
	assign countMask  = boundaryMask(resolution);
	// Tick source: pin falling edges or prescaled instruction clock
	assign countTick  = timer_enable & (event_source_select ? pinFall : preTick);
	assign countNext  = (count_value + 8'h01) & countMask;
	// Overflow at the top of the active range; count goes to zero in PWM, else to the reload value
	assign overflow   = countTick & ((count_value & countMask) == countMask);
	assign enableRise = timer_enable & ~enableSeen;

	// APB decode, zero wait states
	assign busWrite = psel & penable & pwrite;
	assign busRead  = psel & penable & ~pwrite;
	assign wrMode   = busWrite & hit(paddr, `ADDR_MODE);
	assign wrCount  = busWrite & hit(paddr, `ADDR_COUNT);
	assign wrReload = busWrite & hit(paddr, `ADDR_RELOAD);
	assign wrStatus = busWrite & hit(paddr, `ADDR_STATUS);
	assign wrGpio   = busWrite & hit(paddr, `ADDR_GPIO);
	assign mapped   = hit(paddr, `ADDR_MODE) | hit(paddr, `ADDR_COUNT) | hit(paddr, `ADDR_RELOAD)
	                | hit(paddr, `ADDR_STATUS) | hit(paddr, `ADDR_GPIO);

	// Pin ownership: PWM first, toggle only when PWM is off, else last GPIO state
	assign pinOwner = (pwm_output_enable & timer_enable) ? PIN_PWM
	                : (toggle_output_enable & ~pwm_output_enable) ? PIN_TOGGLE
	                : PIN_GPIO;

	////////////////////////////////////////////////////////////////////////
	// Mode and GPIO registers
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			timer_mode_control <= '0;
			gpioOut            <= 1'b0;
			gpioOe             <= 1'b0;
			enableSeen         <= 1'b0;
		end
		else
		begin
			if (wrMode)
				timer_mode_control <= pwdata[`MODE_WIDTH-1:0];
			if (wrGpio)
			begin
				gpioOut <= pwdata[`GPIO_OUT_BIT];
				gpioOe  <= pwdata[`GPIO_OE_BIT];
			end
			enableSeen <= timer_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter. Software write wins over hardware in the same cycle, since
	// it is the only way to set a starting value
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			count_value <= `BYTE_ZERO;
		else if (wrCount)
			count_value <= pwdata[7:0];
		else if (pwmMode & enableRise)
			count_value <= `BYTE_ZERO;
		else if (overflow)
			count_value <= pwmMode ? `BYTE_ZERO : (reload_value & countMask);
		else if (countTick)
			count_value <= countNext;
	end

	////////////////////////////////////////////////////////////////////////
	// Double-buffered reload: the write lands in the buffer, moves across at
	// overflow so a period never sees a half-changed duty
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			reloadBuffer <= `BYTE_ZERO;
			reload_value <= `BYTE_ZERO;
		end
		else
		begin
			if (wrReload)
				reloadBuffer <= pwdata[7:0];
			// While stopped the buffer passes straight through for setup
			if (wrReload & ~timer_enable)
				reload_value <= pwdata[7:0];
			else if (overflow)
				reload_value <= reloadBuffer;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow and pin interrupt flags; hardware set beats software clear
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			overflow_flag      <= 1'b0;
			pin_interrupt_flag <= 1'b0;
		end
		else
		begin
			if (overflow)
				overflow_flag <= 1'b1;
			else if (wrStatus & pwdata[`STAT_OVF_BIT])
				overflow_flag <= 1'b0;
			if (event_source_select)
				pin_interrupt_flag <= 1'b0;
			else if (pinFall)
				pin_interrupt_flag <= 1'b1;
			else if (wrStatus & pwdata[`STAT_PIN_BIT])
				pin_interrupt_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Waveforms: toggle flips per overflow, so one period is two intervals
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			toggleState <= 1'b0;
			pwmState    <= 1'b1;
		end
		else
		begin
			if (overflow)
				toggleState <= ~toggleState;
			if (~pwmMode | enableRise | overflow)
				pwmState <= 1'b1;
			else if (countTick & (countNext == (reload_value & countMask)))
				pwmState <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin mux and flagged outputs, all registered
	logic next_pin;
	logic next_oe_b;
	always_comb
	begin
		next_pin  = gpioOut;
		next_oe_b = ~gpioOe;
		case (pinOwner)
			PIN_PWM:
			begin
				next_pin  = pwmState;
				next_oe_b = 1'b0;
			end
			PIN_TOGGLE:
			begin
				next_pin  = toggleState;
				next_oe_b = 1'b0;
			end
			default:
			begin
				next_pin  = gpioOut;
				next_oe_b = ~gpioOe;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			shared_output_pin <= 1'b0;
			sharedPinOe_b     <= 1'b1;
			overflowIrq       <= 1'b0;
			pinIrq            <= 1'b0;
			pinWake           <= 1'b0;
		end
		else
		begin
			shared_output_pin <= next_pin;
			sharedPinOe_b     <= next_oe_b;
			overflowIrq       <= overflow_flag & overflow_irq_enable;
			pinIrq            <= pin_interrupt_flag & ~event_source_select;
			pinWake           <= powerSaving & pinFall & ~event_source_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB read data and answer; unmapped address answers with pslverr
	logic [31:0] readMux;
	always_comb
	begin
		readMux = 32'h0000_0000;
		case (paddr)
			`ADDR_MODE:   readMux[`MODE_WIDTH-1:0] = timer_mode_control;
			`ADDR_COUNT:  readMux[7:0] = count_value;
			`ADDR_RELOAD: readMux[7:0] = reloadBuffer;
			`ADDR_STATUS:
			begin
				readMux[`STAT_OVF_BIT]  = overflow_flag;
				readMux[`STAT_PIN_BIT]  = pin_interrupt_flag;
				readMux[`STAT_WAKE_BIT] = pinWake;
				readMux[`STAT_LVL_BIT]  = pinLevel;
			end
			`ADDR_GPIO:
			begin
				readMux[`GPIO_OUT_BIT] = gpioOut;
				readMux[`GPIO_OE_BIT]  = gpioOe;
			end
			default: readMux = 32'h0000_0000;
		endcase
	end

	// Registered answer: pready rises with the first access cycle, holds one cycle
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite) ? readMux : prdata;
		end
	end
endmodule

/* File: include/timer_zero_defines.svh */
// Constants for the 8-bit event/buzzer/PWM timer and its APB register map
`ifndef TIMER_ZERO_DEFINES_SVH
`define TIMER_ZERO_DEFINES_SVH

// Register byte offsets
`define ADDR_MODE      12'h000
`define ADDR_COUNT     12'h004
`define ADDR_RELOAD    12'h008
`define ADDR_STATUS    12'h00C
`define ADDR_GPIO      12'h010
`define ADDR_BITS      12

// Mode register field positions
`define MODE_PWM_BIT   0
`define MODE_TOG_BIT   1
`define MODE_ALD_BIT   2
`define MODE_SRC_BIT   3
`define MODE_RATE_LSB  4
`define MODE_RATE_MSB  6
`define MODE_ENB_BIT   7
`define MODE_IEN_BIT   8
`define MODE_WIDTH     9

// Status and GPIO fields
`define STAT_OVF_BIT   0
`define STAT_PIN_BIT   1
`define STAT_WAKE_BIT  2
`define STAT_LVL_BIT   3
`define GPIO_OUT_BIT   0
`define GPIO_OE_BIT    1

// Reset values and count limits
`define BYTE_ZERO      8'h00
`define BYTE_FULL      8'hFF
`define MASK_64        8'h3F
`define MASK_32        8'h1F
`define MASK_16        8'h0F
`define PRESCALE_W     8

`endif

/* File: include/timer_zero_pkg.sv */
// Types shared by the timer block
package timer_zero_pkg;
	// PWM resolution picked by auto-reload and toggle bits
	typedef enum logic [1:0] {RES_256, RES_64, RES_32, RES_16} resolution_t;
	// Pin owner
	typedef enum logic [1:0] {PIN_GPIO, PIN_TOGGLE, PIN_PWM} pin_owner_t;
	typedef logic [7:0] byte_t;
endpackage

/* File: tb/event_source.sv */
// Asynchronous falling-edge source driving the event input pin
`timescale 1ns/1ps
module event_source
(
	// Request and speed
	input wire logic [7:0] want,
	input wire logic       slow,
	// Pin and progress
	output logic           pinOut,
	output logic [7:0]     falls
);
	// Pin idles high like a pulled-up input; the phase never follows the bench clock
	initial
	begin
		pinOut = 1'b1;
		falls = 8'h00;
		forever
		begin
			#1.3;
			if (falls != want)
			begin
				#(slow ? 37 : 13) pinOut = 1'b0;
				falls = falls + 8'h01;
				#(slow ? 37 : 13) pinOut = 1'b1;
			end
		end
	end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench: APB sequences against the timer block
`timescale 1ns/1ps
`include "timer_zero_defines.svh"
module tb_top;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        evPin;
	logic        powerSaving = 1'b0;
	logic        pinWake;
	logic        pinIrq;
	logic        outPin;
	logic        outOe_b;
	logic        overflowIrq;
	logic        lastPin = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  want = 8'h00;
	logic [7:0]  falls;
	logic [31:0] rd;
	logic        err;
	int          bad_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          wakes = 0;
	int          rise = 0;
	int          hw[$];
	int          pw[$];
	int          k;
	int          d;

	// 250 MHz clock
	always #2 clock = ~clock;

	// Design and far-side pulse source
	timer_zero DUT (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.event_input_pin(evPin), .powerSaving, .pinWake, .pinIrq, .shared_output_pin(outPin),
		.sharedPinOe_b(outOe_b), .overflowIrq);
	event_source SRC (.want, .slow, .pinOut(evPin), .falls);

	// Wake pulses and pin widths, sampled mid-cycle where outputs are settled
	always @(negedge clock)
	begin
		cyc++;
		wakes += int'(pinWake === 1'b1);
		if (outPin === 1'b1 && lastPin === 1'b0)
		begin
			pw.push_back(cyc - rise);
			rise = cyc;
		end
		if (outPin === 1'b0 && lastPin === 1'b1)
			hw.push_back(cyc - rise);
		lastPin = outPin;
	end

	////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clock);
		penable <= 1'b1;
		// Answer and read data are taken at the rising edge that sees pready
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Ask the source for more falls, then allow for the synchroniser
	task automatic pulses(input logic [7:0] total);
		want <= total;
		do
			@(posedge clock);
		while (falls !== total);
		repeat (6) @(posedge clock);
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////
	// Watchdog well beyond the expected run of some 10000 cycles
	initial
	begin
		repeat (60000) @(posedge clock);
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// Test sequence
	initial
	begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		apb(1'b0, `ADDR_MODE, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd, 32'h8);
		apb(1'b1, 12'h014, 32'hFF);
		check(err, 32'h1);
		apb(1'b0, 12'h014, 32'h0);
		check(rd, 32'h0);
		$display("Test reset done");
		// Every prescale code: from 0xFC, overflow three to four divided ticks after enable
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, `ADDR_COUNT, 32'hFC);
			apb(1'b1, `ADDR_RELOAD, 32'hFC);
			apb(1'b1, `ADDR_MODE, 32'h180 | (c << 4));
			d = cyc;
			k = 0;
			do
			begin
				@(posedge clock);
				k++;
			end
			while (overflowIrq !== 1'b1 && k < 2000);
			d = cyc - d;
			check(32'(d >= 3 * (256 >> c) - 2 && d <= 4 * (256 >> c) + 6), 32'h1);
			apb(1'b0, `ADDR_COUNT, 32'h0);
			if (c < 6)
				check(rd[7:2], 32'h3F);
			apb(1'b1, `ADDR_MODE, 32'h0);
			apb(1'b1, `ADDR_STATUS, 32'h1);
		end
		$display("Test prescale done");
		// Event counting while asleep: only pin falls move the count, fastest prescale ignored
		apb(1'b1, `ADDR_COUNT, 32'hF0);
		apb(1'b1, `ADDR_RELOAD, 32'hF0);
		powerSaving <= 1'b1;
		apb(1'b1, `ADDR_MODE, 32'hF8);
		pulses(8'h05);
		repeat (40) @(posedge clock);
		apb(1'b0, `ADDR_COUNT, 32'h0);
		check(rd, 32'hF5);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd[1], 32'h0);
		check(pinIrq, 32'h0);
		slow <= 1'b1;
		pulses(8'h10);
		apb(1'b0, `ADDR_COUNT, 32'h0);
		check(rd, 32'hF0);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd[0], 32'h1);
		check(wakes, 32'h0);
		apb(1'b1, `ADDR_MODE, 32'h0);
		pulses(8'h11);
		check(wakes, 32'h1);
		check(pinIrq, 32'h1);
		powerSaving <= 1'b0;
		$display("Test event done");
		// Toggle: overflow every 4 cycles gives an 8-cycle half-duty square wave
		apb(1'b1, `ADDR_GPIO, 32'h3);
		apb(1'b1, `ADDR_COUNT, 32'hFE);
		apb(1'b1, `ADDR_RELOAD, 32'hFE);
		apb(1'b1, `ADDR_MODE, 32'hF2);
		repeat (60) @(posedge clock);
		check(pw[$], 32'h8);
		check(hw[$], 32'h4);
		apb(1'b1, `ADDR_MODE, 32'hF0);
		apb(1'b1, `ADDR_STATUS, 32'h1);
		check({outOe_b, outPin}, 32'h1);
		repeat (20) @(posedge clock);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd[0], 32'h1);
		$display("Test toggle done");
		// PWM at each resolution with prescale codes 7 down to 4: period from boundary, high width from duty
		for (int r = 0; r < 4; r++)
		begin
			apb(1'b1, `ADDR_MODE, 32'h0);
			apb(1'b1, `ADDR_COUNT, 32'h0);
			apb(1'b1, `ADDR_RELOAD, 32'h4);
			apb(1'b1, `ADDR_MODE, 32'h81 | (r << 1) | ((7 - r) << 4));
			repeat (1600) @(posedge clock);
			check(pw[$], r ? 256 : 512);
			check(hw[$], 8 << r);
			check(outOe_b, 32'h0);
		end
		// New duty mid-period shows only from the following period
		k = pw.size();
		while (pw.size() == k)
			@(posedge clock);
		k = hw.size();
		apb(1'b1, `ADDR_RELOAD, 32'hC);
		repeat (600) @(posedge clock);
		check(hw[k], 32'h40);
		check(hw[k + 1], 32'hC0);
		apb(1'b1, `ADDR_GPIO, 32'h0);
		apb(1'b1, `ADDR_MODE, 32'hC0);
		repeat (3) @(posedge clock);
		check(outOe_b, 32'h1);
		$display("Test PWM done");
		report_and_stop();
	end
endmodule

/* File: tb/timer_zero_monitor.sv */
// Port-level assertions for the timer block, attached by bind
`timescale 1ns/1ps
`include "timer_zero_defines.svh"
module timer_zero_monitor
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic        pinWake,
	input wire logic        pinIrq,
	input wire logic        sharedPinOe_b,
	input wire logic        overflowIrq
);
	logic [8:0] mode;
	logic [1:0] gpio;
	logic [2:0] quiet;
	wire        wr     = psel && penable && pready && pwrite;
	wire        modeWr = wr && paddr == `ADDR_MODE;
	wire        gpioWr = wr && paddr == `ADDR_GPIO;

	// Shadow of mode and GPIO; outputs lag a write, so checks wait for quiet
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			mode <= 9'h000;
			gpio <= 2'h0;
		end
		else
		begin
			mode <= modeWr ? pwdata[8:0] : mode;
			gpio <= gpioWr ? pwdata[1:0] : gpio;
		end
	end

	// Saturating count of edges since the last configuration write
	always_ff @(posedge clock)
	begin
		if (!rst_b || modeWr || gpioWr)
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end

	////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_ready_follows: assert property (psel && !penable |=> pready && psel && penable)
		else $error("pready missing in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_wake_blocked: assert property (quiet > 3'h2 && mode[3] |-> !pinWake)
		else $error("wake in event mode");
	a_pin_irq_off: assert property (quiet > 3'h2 && mode[3] |-> !pinIrq)
		else $error("pin interrupt in event mode");
	a_gpio_back: assert property (quiet > 3'h2 && !mode[0] && !mode[1] |-> sharedPinOe_b == !gpio[1])
		else $error("pin not returned to GPIO");
	a_toggle_owns: assert property (quiet > 3'h2 && mode[1] && !mode[0] |-> !sharedPinOe_b)
		else $error("toggle not driving pin");
	a_pwm_owns: assert property (quiet > 3'h2 && mode[0] && mode[7] && !mode[3] |-> !sharedPinOe_b)
		else $error("PWM not driving pin");
	a_irq_enabled: assert property (quiet > 3'h2 && !mode[8] |-> !overflowIrq)
		else $error("overflow interrupt while disabled");
endmodule

bind timer_zero timer_zero_monitor MON (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .pinWake, .pinIrq, .sharedPinOe_b, .overflowIrq);
